/* src/prc_core.sv */
// prc_core.sv: response sizing, identity words, checksum, acknowledge timing
// assumes: system clock 125 MHz; prog_clock_line is a second clock domain
`timescale 1ns/1ps
`include "prc_regs.svh"
module prc_core #(
	parameter logic [15:0] PART_ID = 16'h0A5C, // arbitrary value
	parameter logic [15:0] SIL_REV = 16'h0001, // arbitrary value
	parameter logic [3:0] READ_OPCODE = 4'h1,
	parameter int ERASE_MIN_CYC = `PRC_ERASE_MIN_MS * 1000 * `PRC_CLK_MHZ
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [23:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_prog_clock_line,
	input wire logic i_master_clear_pin,
	input wire logic i_prog_data_line_in,
	output logic o_prog_data_line_out,
	output logic o_prog_data_line_oe,
	output logic o_packed_valid,
	output logic [47:0] o_packed_data
);
	localparam int PROC_CYC = `PRC_PROC_US * `PRC_CLK_MHZ;
	localparam int REL_CYC = `PRC_REL_MIN_US * `PRC_CLK_MHZ + 8;
	localparam int CNT_W = 22;

	// command and response registers
	logic [3:0] cmd_op_q;
	logic [15:0] cmd_n_q;
	logic [15:0] resp0_q;
	logic [15:0] resp_len_q;
	logic prot_q;
	logic [15:0] sum_q;
	logic [23:0] pend_word_q;
	logic pend_q;
	logic [CNT_W-1:0] cnt_q;
	prc_pkg::prc_state_t st_q;
	logic busy_q;
	logic [31:0] rdata_q;
	logic [47:0] packed_q;
	logic packed_v_q;

	// link domain: one toggle per rising programmer clock edge
	logic [1:0] lmclr_q;
	logic tog_q;
	logic [2:0] tog_sync_q;
	logic link_seen_q;
	logic master_clear_pin_s1_q;
	logic master_clear_pin_s2_q;
	logic din_s1_q;
	logic din_s2_q;

	always_ff @(posedge i_prog_clock_line) begin
		lmclr_q <= {lmclr_q[0], i_master_clear_pin};
	end

	// toggle held clear while the master clear pin is high
	always_ff @(posedge i_prog_clock_line) begin
		if (lmclr_q[1]) begin
			tog_q <= 1'b0;
		end else begin
			tog_q <= ~tog_q;
		end
	end

	always_ff @(posedge i_clk) begin
		tog_sync_q <= {tog_sync_q[1:0], tog_q};
		master_clear_pin_s1_q <= i_master_clear_pin;
		master_clear_pin_s2_q <= master_clear_pin_s1_q;
		din_s1_q <= i_prog_data_line_in;
		din_s2_q <= din_s1_q;
	end

	wire link_edge = tog_sync_q[2] ^ tog_sync_q[1];
	wire in_prog = ~master_clear_pin_s2_q;

	// programmer clock activity seen in programming mode
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			link_seen_q <= 1'b0;
		end else if (link_edge && in_prog) begin
			link_seen_q <= 1'b1;
		end else if (!in_prog) begin
			link_seen_q <= 1'b0;
		end
	end

	wire cmd_wr = i_wr && i_addr == `PRC_ADDR_CMD;
	wire [3:0] new_op = i_wdata[15:12];
	wire [15:0] new_n = i_wdata[31:16];
	wire is_read = new_op == READ_OPCODE;
	wire [17:0] n3 = 18'(new_n) * 18'd3;
	wire [17:0] n3_odd = 18'(new_n + 16'h0001) * 18'd3;

	// response length in 16-bit words
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cmd_op_q <= 4'h0;
			cmd_n_q <= 16'h0000;
			resp_len_q <= `PRC_HDR_WORDS;
			resp0_q <= 16'h0000;
		end else if (cmd_wr && !busy_q) begin
			cmd_op_q <= new_op;
			cmd_n_q <= new_n;
			resp0_q <= {prc_pkg::PRC_RSP_PASS, new_op, 8'h00};
			if (!is_read) begin
				resp_len_q <= `PRC_HDR_WORDS;
			end else if (new_n[0]) begin
				resp_len_q <= 16'(n3_odd >> 1) + `PRC_HDR_WORDS;
			end else begin
				resp_len_q <= 16'(n3 >> 1) + `PRC_HDR_WORDS;
			end
		end
	end

	// packing of two 24-bit program words into three 16-bit words
	wire code_wr = i_wr && i_addr == `PRC_ADDR_CODE;
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pend_q <= 1'b0;
			pend_word_q <= 24'h000000;
			packed_q <= 48'h000000000000;
			packed_v_q <= 1'b0;
		end else begin
			packed_v_q <= 1'b0;
			if (code_wr && cmd_op_q == READ_OPCODE) begin
				if (!pend_q) begin
					pend_word_q <= i_wdata[23:0];
					pend_q <= 1'b1;
				end else begin
					// lsw1, msb2:msb1, lsw2
					packed_q <= {i_wdata[15:0], i_wdata[23:16],
						pend_word_q[23:16], pend_word_q[15:0]};
					packed_v_q <= 1'b1;
					pend_q <= 1'b0;
				end
			end else if (cmd_wr && pend_q) begin
				// odd count: last word padded with zero
				packed_q <= {16'h0000, 8'h00, pend_word_q[23:16],
					pend_word_q[15:0]};
				packed_v_q <= 1'b1;
				pend_q <= 1'b0;
			end
		end
	end

	// masked byte-sum checksum
	wire [23:0] cfg_in = i_wdata[23:0];
	prc_pkg::prc_cfg_sel_t cfg_sel;
	assign cfg_sel = prc_pkg::prc_cfg_sel_t'(i_wdata[25:24]);
	logic [23:0] cfg_masked;
	always_comb begin
		case (cfg_sel)
			prc_pkg::PRC_CFG_SEC: cfg_masked = cfg_in & `PRC_MASK_SEC;
			prc_pkg::PRC_CFG_BSLIM: cfg_masked = cfg_in & `PRC_MASK_BSLIM;
			prc_pkg::PRC_CFG_OSC: cfg_masked = cfg_in & `PRC_MASK_OSC;
			default: cfg_masked = cfg_in;
		endcase
	end
	wire [23:0] lo_lim = prot_q ? `PRC_CODE_PROT_LO : `PRC_CODE_LO;
	logic [23:0] code_loc_q;
	wire in_range = code_loc_q >= lo_lim && code_loc_q <= `PRC_CODE_HI;
	wire cfg_wr = i_wr && i_addr == `PRC_ADDR_CFG;
	wire sum_clr = i_wr && i_addr == `PRC_ADDR_CTRL &&
		i_wdata[`PRC_CTRL_SUMCLR_BIT];
	function automatic logic [15:0] byte_sum(input logic [23:0] w);
		byte_sum = 16'(w[7:0]) + 16'(w[15:8]) + 16'(w[23:16]);
	endfunction : byte_sum

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			code_loc_q <= 24'h000000;
		end else if (sum_clr) begin
			code_loc_q <= 24'h000000;
		end else if (code_wr) begin
			code_loc_q <= code_loc_q + 24'h000002;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sum_q <= 16'h0000;
		end else if (sum_clr) begin
			sum_q <= 16'h0000;
		end else if (code_wr && in_range) begin
			sum_q <= sum_q + byte_sum(i_wdata[23:0]);
		end else if (cfg_wr) begin
			sum_q <= sum_q + byte_sum(cfg_masked);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			prot_q <= 1'b0;
		end else if (i_wr && i_addr == `PRC_ADDR_CTRL) begin
			prot_q <= i_wdata[`PRC_CTRL_PROT_BIT];
		end
	end

	// executive timing: processing, acknowledge low, bulk erase
	wire erase_req = i_wr && i_addr == `PRC_ADDR_CTRL &&
		i_wdata[`PRC_CTRL_ERASE_BIT];
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_q <= prc_pkg::PRC_ST_IDLE;
			cnt_q <= '0;
			busy_q <= 1'b0;
			o_prog_data_line_out <= 1'b1;
			o_prog_data_line_oe <= 1'b1;
		end else begin
			case (st_q)
				prc_pkg::PRC_ST_IDLE: begin
					o_prog_data_line_oe <= 1'b1;
					if (erase_req) begin
						st_q <= prc_pkg::PRC_ST_ERASE;
						cnt_q <= CNT_W'(ERASE_MIN_CYC - 1);
						busy_q <= 1'b1;
					end else if (cmd_wr && in_prog) begin
						st_q <= prc_pkg::PRC_ST_PROC;
						cnt_q <= CNT_W'(PROC_CYC - 2);
						busy_q <= 1'b1;
					end
				end
				prc_pkg::PRC_ST_PROC: begin
					if (cnt_q == '0) begin
						st_q <= prc_pkg::PRC_ST_ACK;
						o_prog_data_line_out <= 1'b0;
						o_prog_data_line_oe <= 1'b0;
						cnt_q <= CNT_W'(REL_CYC - 1);
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				prc_pkg::PRC_ST_ACK: begin
					if (cnt_q == '0) begin
						st_q <= prc_pkg::PRC_ST_IDLE;
						o_prog_data_line_out <= 1'b1;
						o_prog_data_line_oe <= 1'b1;
						busy_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				prc_pkg::PRC_ST_ERASE: begin
					if (cnt_q == '0) begin
						st_q <= prc_pkg::PRC_ST_IDLE;
						busy_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				default: begin
					st_q <= prc_pkg::PRC_ST_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	// register read port; identity words have no write path
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rdata_q <= 32'h00000000;
		end else if (i_rd) begin
			case (i_addr)
				`PRC_ADDR_PART_ID: rdata_q <= {16'h0000, PART_ID};
				`PRC_ADDR_SIL_REV: rdata_q <= {16'h0000, SIL_REV};
				`PRC_ADDR_CTRL: rdata_q <= {31'h00000000, prot_q};
				`PRC_ADDR_CMD: rdata_q <= {cmd_n_q, 12'h000, cmd_op_q};
				`PRC_ADDR_RESP0: rdata_q <= {16'h0000, resp0_q};
				`PRC_ADDR_RESP1: rdata_q <= {16'h0000, resp_len_q};
				`PRC_ADDR_SUM: rdata_q <= {16'h0000, sum_q};
				`PRC_ADDR_STAT: rdata_q <= {24'h000000, 1'b0,
					link_seen_q, din_s2_q, in_prog, 1'b0, st_q[1:0],
					busy_q};
				default: rdata_q <= 32'h00000000;
			endcase
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

	assign o_rdata = rdata_q;
	assign o_packed_data = packed_q;
	assign o_packed_valid = packed_v_q;
endmodule : prc_core

/* src/prc_pkg.sv */
// prc_pkg.sv: types shared by the programming-support block
// assumes: prc_regs.svh supplies the numeric constants
package prc_pkg;
	typedef enum logic [3:0] {
		PRC_RSP_PASS = 4'h1,
		PRC_RSP_FAIL = 4'h2,
		PRC_RSP_NACK = 4'h3
	} prc_resp_t;
	typedef enum logic [2:0] {
		PRC_ST_IDLE = 3'b000,
		PRC_ST_PROC = 3'b001,
		PRC_ST_ACK = 3'b010,
		PRC_ST_HOLD = 3'b011,
		PRC_ST_ERASE = 3'b100
	} prc_state_t;
	typedef enum logic [1:0] {
		PRC_CFG_SEC = 2'b00,
		PRC_CFG_BSLIM = 2'b01,
		PRC_CFG_OSC = 2'b10,
		PRC_CFG_OTHER = 2'b11
	} prc_cfg_sel_t;
endpackage : prc_pkg

/* src/prc_regs.svh */
// prc_regs.svh: register offsets, masks, reset values and timing limits in microseconds and milliseconds
// assumes: included by the block, its checks and the testbench; 125 MHz system clock
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH
`define PRC_CLK_MHZ 125
`define PRC_ADDR_PART_ID 24'hFF0000
`define PRC_ADDR_SIL_REV 24'hFF0002
`define PRC_ADDR_CTRL 24'hFF0010
`define PRC_ADDR_CMD 24'hFF0014
`define PRC_ADDR_RESP0 24'hFF0018
`define PRC_ADDR_RESP1 24'hFF001C
`define PRC_ADDR_CODE 24'hFF0020
`define PRC_ADDR_CFG 24'hFF0024
`define PRC_ADDR_SUM 24'hFF0028
`define PRC_ADDR_STAT 24'hFF002C
`define PRC_MASK_SEC 24'h008FEF
`define PRC_MASK_BSLIM 24'h001FFF
`define PRC_MASK_OSC 24'h000087
`define PRC_CODE_LO 24'h000000
`define PRC_CODE_PROT_LO 24'h02A800
`define PRC_CODE_HI 24'h02AB7E
`define PRC_HDR_WORDS 16'h0002
`define PRC_PROC_US 10
`define PRC_REL_MIN_US 15
`define PRC_REL_MAX_US 23
`define PRC_ERASE_MIN_MS 16
`define PRC_ERASE_MAX_MS 24
`define PRC_CTRL_PROT_BIT 0
`define PRC_CTRL_SUMCLR_BIT 1
`define PRC_CTRL_ERASE_BIT 2
`endif

/* test/prc_core_props.sv */
// prc_core_props.sv: port checks for prc_core
// assumes: bound to every prc_core, single system clock domain
`timescale 1ns/1ps
`include "prc_regs.svh"
module prc_core_props #(
	parameter logic [15:0] PART_ID = 16'h0A5C,
	parameter logic [15:0] SIL_REV = 16'h0001
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [23:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_master_clear_pin,
	input logic [31:0] o_rdata,
	input logic o_prog_data_line_out,
	input logic o_prog_data_line_oe,
	input logic o_packed_valid,
	input logic [47:0] o_packed_data
);
	logic [11:0] low_q;
	logic [11:0] wait_q;
	default clocking dc @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// cycles the line has been held low
	always_ff @(posedge i_clk)
		low_q <= o_prog_data_line_oe ? 12'h000 : low_q + 12'h001;
	// cycles since an accepted command while the line stays released
	always_ff @(posedge i_clk) begin
		if (i_reset || !o_prog_data_line_oe) begin
			wait_q <= 12'h000;
		end else if (wait_q != 12'h000) begin
			wait_q <= wait_q + 12'h001;
		end else if (i_wr && i_addr == `PRC_ADDR_CMD &&
			!i_master_clear_pin && !$past(i_master_clear_pin, 2)) begin
			wait_q <= 12'h001;
		end
	end
	id_word_a: assert property (i_rd && i_addr == `PRC_ADDR_PART_ID |=>
		o_rdata == {16'h0000, PART_ID}) else $error("part id wrong");
	rev_word_a: assert property (i_rd && i_addr == `PRC_ADDR_SIL_REV |=>
		o_rdata == {16'h0000, SIL_REV}) else $error("revision wrong");
	sum_width_a: assert property (i_rd && i_addr == `PRC_ADDR_SUM |=>
		o_rdata[31:16] == 16'h0000) else $error("sum too wide");
	ack_low_a: assert property (!o_prog_data_line_oe |->
		!o_prog_data_line_out) else $error("ack not low");
	ack_len_a: assert property ($rose(o_prog_data_line_oe) |->
		low_q inside {[1875:2875]}) else $error("ack length");
	proc_time_a: assert property (wait_q <= 12'h4E2)
		else $error("command too slow");
	pack_src_a: assert property (o_packed_valid |-> $past(i_wr) &&
		($past(i_addr) == `PRC_ADDR_CODE || $past(i_addr) == `PRC_ADDR_CMD))
		else $error("stray packed group");
	pack_data_a: assert property (o_packed_valid &&
		$past(i_addr) == `PRC_ADDR_CODE |->
		o_packed_data[47:32] == $past(i_wdata[15:0]) &&
		o_packed_data[31:24] == $past(i_wdata[23:16]))
		else $error("packed second word wrong");
endmodule : prc_core_props
bind prc_core prc_core_props #(.PART_ID(PART_ID), .SIL_REV(SIL_REV)) u_props (
	.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .i_master_clear_pin,
	.o_rdata, .o_prog_data_line_out, .o_prog_data_line_oe, .o_packed_valid,
	.o_packed_data);

/* test/prc_prog_model.sv */
// prc_prog_model.sv: programmer at the far side of the serial pins
// assumes: data line pulled up; link clock runs only within frames
`timescale 1ns/1ps
module prc_prog_model (
	output logic o_clk_line,
	output logic o_master_clear_pin,
	input wire logic i_line
);
	realtime fall_t = 0;
	realtime ack_ns = 0;
	initial begin
		o_clk_line = 1'b0;
		o_master_clear_pin = 1'b1;
	end
	// width of the low pulse on the line
	always @(negedge i_line) fall_t = $realtime;
	always @(posedge i_line) ack_ns = $realtime - fall_t;
	task enter;
		o_master_clear_pin = 1'b0;
	endtask : enter
	task frame(input int n);
		#5;
		repeat (n) begin
			o_clk_line = 1'b1;
			#32 o_clk_line = 1'b0;
			#32;
		end
	endtask : frame
endmodule : prc_prog_model

/* test/testbench.sv */
// testbench.sv: register level tests of prc_core
// assumes: prc_regs.svh on the include path, programmer model alongside
`timescale 1ns/1ps
`include "prc_regs.svh"
module testbench;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [23:0] i_addr = 24'h000000;
	logic [31:0] i_wdata = 32'h00000000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata, rv;
	logic lclk, master_clear_pin, dout, doe, pv;
	logic [47:0] pd, pk;
	logic [15:0] es;
	wire line = doe ? 1'b1 : dout;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	int t0;
	logic [3:0] ops [8] = '{4'h0, 4'h5, 4'hF, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
	logic [15:0] ns [8] = '{16'h0009, 16'h0003, 16'h0000, 16'h0001,
		16'h0002, 16'h0003, 16'h0004, 16'h0100};
	// id values arbitrary
	prc_core #(.PART_ID(16'h1234), .SIL_REV(16'h0042), .ERASE_MIN_CYC(200))
	DUT (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_prog_clock_line(lclk), .i_master_clear_pin(master_clear_pin),
		.i_prog_data_line_in(line), .o_prog_data_line_out(dout),
		.o_prog_data_line_oe(doe), .o_packed_valid(pv), .o_packed_data(pd));
	prc_prog_model prog (.o_clk_line(lclk), .o_master_clear_pin(master_clear_pin), .i_line(line));
	function automatic logic [15:0] bs(logic [23:0] w);
		return {8'h00, w[7:0]} + {8'h00, w[15:8]} + {8'h00, w[23:16]};
	endfunction : bs
	function automatic logic [15:0] rlen(logic [3:0] op, logic [15:0] n);
		if (op != 4'h1)
			return 16'h0002;
		return n[0] ? 16'(3 * (n + 1) / 2 + 2) : 16'(3 * n / 2 + 2);
	endfunction : rlen
	task results;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	task cmp(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : cmp
	task wr(input logic [23:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task rd(input logic [23:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		rv = o_rdata;
	endtask : rd
	task chk(input logic [23:0] a, input logic [31:0] e);
		rd(a);
		cmp(rv, e);
	endtask : chk
	task idle;
		rd(`PRC_ADDR_STAT);
		while (rv[0] !== 1'b0)
			rd(`PRC_ADDR_STAT);
	endtask : idle
	task code(input logic [23:0] w, input bit add);
		wr(`PRC_ADDR_CODE, {8'h00, w});
		if (add)
			es = es + bs(w);
	endtask : code
	initial begin
		forever #4 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (pv)
			pk <= pd;
		cyc++;
		if (cyc == 60000) begin
			fails++;
			$display("[ERR] %0t timeout", $time);
			results();
		end
	end
	initial begin
		repeat (4) @(posedge i_clk);
		i_reset <= 1'b0;
		chk(`PRC_ADDR_PART_ID, 32'h00001234);
		chk(`PRC_ADDR_SIL_REV, 32'h00000042);
		wr(`PRC_ADDR_PART_ID, 32'h0000FFFF);
		wr(`PRC_ADDR_SIL_REV, 32'h0000FFFF);
		wr(`PRC_ADDR_CTRL, 32'h00000001);
		chk(`PRC_ADDR_PART_ID, 32'h00001234);
		chk(`PRC_ADDR_SIL_REV, 32'h00000042);
		chk(24'hFF0030, 32'h00000000);
		$display("test identity done");
		prog.frame(3);
		prog.enter();
		prog.frame(4);
		chk(`PRC_ADDR_STAT, 32'h00000070);
		for (int i = 0; i < 8; i++) begin
			prog.ack_ns = 0;
			wr(`PRC_ADDR_CMD, {ns[i], ops[i], 12'h000});
			prog.frame(2);
			idle();
			chk(`PRC_ADDR_RESP0, {20'h00001, ops[i], 8'h00});
			chk(`PRC_ADDR_RESP1, {16'h0000, rlen(ops[i], ns[i])});
			cmp(32'(prog.ack_ns >= 15000 && prog.ack_ns <= 23000), 32'h1);
		end
		$display("test responses done");
		wr(`PRC_ADDR_CTRL, 32'h00000002);
		wr(`PRC_ADDR_CTRL, 32'h00000000);
		es = 16'h0000;
		code(24'hA1B2C3, 1'b1);
		code(24'hD4E5F6, 1'b1);
		chk(`PRC_ADDR_SUM, {16'h0000, es});
		cmp(pk[31:0], 32'hD4A1B2C3);
		cmp({16'h0000, pk[47:32]}, 32'h0000E5F6);
		for (int s = 0; s < 4; s++)
			wr(`PRC_ADDR_CFG, {6'h00, 2'(s), 24'hFFFFFF});
		es = es + bs(`PRC_MASK_SEC) + bs(`PRC_MASK_BSLIM) + bs(`PRC_MASK_OSC);
		es = es + bs(24'hFFFFFF);
		chk(`PRC_ADDR_SUM, {16'h0000, es});
		repeat (100) code(24'hFFFFFF, 1'b1);
		chk(`PRC_ADDR_SUM, {16'h0000, es});
		wr(`PRC_ADDR_CTRL, 32'h00000003);
		wr(`PRC_ADDR_CTRL, 32'h00000001);
		code(24'hFFFFFF, 1'b0);
		wr(`PRC_ADDR_CFG, {8'h02, 24'hFFFFFF});
		chk(`PRC_ADDR_SUM, {16'h0000, bs(`PRC_MASK_OSC)});
		wr(`PRC_ADDR_CMD, {16'h0001, 4'h1, 12'h000});
		idle();
		cmp(pk[31:0], 32'h00FFFFFF);
		cmp({16'h0000, pk[47:32]}, 32'h00000000);
		$display("test checksum done");
		wr(`PRC_ADDR_CTRL, 32'h00000004);
		t0 = cyc;
		repeat (150) @(posedge i_clk);
		rd(`PRC_ADDR_STAT);
		cmp({31'h0, rv[0]}, 32'h00000001);
		idle();
		cmp(32'(cyc - t0 <= 305), 32'h00000001);
		$display("test erase done");
		results();
	end
endmodule : testbench
